// ---- ssq_act_if.sv ----
// interface: stop cause and chosen actions between sequencer and decoder
`timescale 1ns/1ps
interface ssq_act_if;
	ssq_pkg::ssq_cause_e cause; // requested stop cause
	ssq_pkg::ssq_act_s act; // actions for that cause
	modport dec (input cause, output act);
	modport seq (output cause, input act);
endinterface

// ---- ssq_decode.sv ----
// module: translates a stop cause and the sequence settings into actions
`timescale 1ns/1ps
module ssq_decode (
	// sequence settings
	input wire logic [1:0] overtravel_stop_sequence,
	input wire logic [3:0] servo_off_sequence,
	input wire logic [3:0] main_power_off_sequence,
	input wire logic [2:0] alarm_sequence,
	input wire logic error_needs_immediate_stop,
	// cause in, actions out
	ssq_act_if.dec act_if
);

	logic [3:0] soff_code; // servo off code, illegal values fall back to 0
	logic [3:0] mpo_code; // main power off code, illegal values fall back to 0

	// codes above the legal range act as the safest code, 0
	always_comb begin
		soff_code = (servo_off_sequence > ssq_pkg::OFF_SEQ_LAST) ? 4'h0 : servo_off_sequence;
		mpo_code = (main_power_off_sequence > ssq_pkg::OFF_SEQ_LAST) ? 4'h0 : main_power_off_sequence;
	end

	// action table per cause
	always_comb begin
		act_if.act = ssq_pkg::ACT_NONE;
		unique case (act_if.cause)
			ssq_pkg::CS_NONE: begin
				act_if.act = ssq_pkg::ACT_NONE;
			end
			ssq_pkg::CS_OT_FWD, ssq_pkg::CS_OT_REV: begin
				if (overtravel_stop_sequence == ssq_pkg::OT_SEQ_IMMEDIATE) begin
					act_if.act.decel_immediate = 1'b1;
					act_if.act.after_lock = 1'b1;
					act_if.act.clear_start = 1'b1;
					act_if.act.clear_end = 1'b1;
				end else if (overtravel_stop_sequence == ssq_pkg::OT_SEQ_ZERO_TORQUE) begin
					act_if.act.decel_zero_torque = 1'b1;
					act_if.act.after_zero_torque = 1'b1;
				end else begin
					// code 0 and the illegal code 3 both brake
					act_if.act.decel_brake = 1'b1;
					act_if.act.after_zero_torque = 1'b1;
				end
			end
			ssq_pkg::CS_SERVO_OFF: begin
				act_if.act.decel_immediate = (soff_code >= ssq_pkg::OFF_SEQ_IMM_FIRST);
				act_if.act.decel_brake = (soff_code < ssq_pkg::OFF_SEQ_IMM_FIRST);
				// codes 0,1,4,5,8 keep braking: bit 1 clear, but the top code 9
				// shares that bit pattern and must run free
				act_if.act.after_brake = ~soff_code[1] && (soff_code != ssq_pkg::OFF_SEQ_LAST);
				act_if.act.clear_start = (soff_code < ssq_pkg::OFF_SEQ_RETAIN_FIRST)
					|| (soff_code >= ssq_pkg::OFF_SEQ_IMM_FIRST);
				act_if.act.clear_end = (soff_code >= ssq_pkg::OFF_SEQ_IMM_FIRST);
			end
			ssq_pkg::CS_MAINS_OFF: begin
				act_if.act.decel_immediate = (mpo_code >= ssq_pkg::OFF_SEQ_IMM_FIRST);
				act_if.act.decel_brake = (mpo_code < ssq_pkg::OFF_SEQ_IMM_FIRST);
				act_if.act.after_brake = 1'b1;
				act_if.act.clear_start = (mpo_code < ssq_pkg::OFF_SEQ_RETAIN_FIRST)
					|| (mpo_code >= ssq_pkg::OFF_SEQ_IMM_FIRST);
				act_if.act.clear_end = act_if.act.clear_start;
			end
			ssq_pkg::CS_ALARM: begin
				// immediate stop only for alarms that ask for it
				act_if.act.decel_immediate = (alarm_sequence >= ssq_pkg::ALM_SEQ_IMM_FIRST)
					&& error_needs_immediate_stop;
				act_if.act.decel_brake = ~act_if.act.decel_immediate;
				act_if.act.after_brake = 1'b1;
			end
		endcase
	end

endmodule

// ---- ssq_motor_model.sv ----
// partner: motor and power stage that slows the shaft while a stop runs
`timescale 1ns/1ps
module ssq_motor_model (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// sequencer state and bench controls
	input wire logic stop_active,
	input wire logic after_stop,
	input wire logic slow,
	input wire logic kick,
	// shaft speed in r/min
	output logic [15:0] motor_speed
);
	// step per cycle; slow models a heavy load that coasts for a long time
	logic [15:0] step;
	assign step = slow ? 16'h0001 : 16'h0040;
	// speed only falls in a stop: the host sends nothing toward the blocked side
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			motor_speed <= 16'h0400;
		end else if (!stop_active || kick) begin
			motor_speed <= 16'h0400; // running, or shaft pushed after the halt
		end else if (!after_stop) begin
			motor_speed <= (motor_speed > step) ? motor_speed - step : 16'h0000;
		end
	end
endmodule

// ---- ssq_pkg.sv ----
// package: constants, enumerations and action layout of the servo stop sequencer
package ssq_pkg;

	// overtravel input handling modes
	localparam logic [1:0] OT_MODE_NORMAL = 2'h0; // limits block their own direction
	localparam logic [1:0] OT_MODE_IGNORE = 2'h1; // limits have no effect
	localparam logic [1:0] OT_MODE_ALARM = 2'h2; // any limit raises the overtravel alarm

	// overtravel stop sequence codes
	localparam logic [1:0] OT_SEQ_BRAKE = 2'h0; // braking while slowing, zero torque after
	localparam logic [1:0] OT_SEQ_ZERO_TORQUE = 2'h1; // zero torque while slowing and after
	localparam logic [1:0] OT_SEQ_IMMEDIATE = 2'h2; // immediate stop, servo lock after

	// servo off and main power off sequence codes
	localparam logic [3:0] OFF_SEQ_RETAIN_FIRST = 4'h4; // first code that keeps the deviation
	localparam logic [3:0] OFF_SEQ_IMM_FIRST = 4'h8; // first code with an immediate stop
	localparam logic [3:0] OFF_SEQ_LAST = 4'h9; // highest legal code

	// alarm sequence codes
	localparam logic [2:0] ALM_SEQ_IMM_FIRST = 3'h4; // first code allowing an immediate stop

	// speed at or below which deceleration counts as finished, in r/min
	localparam logic [15:0] STOP_SPEED_RPM = 16'h001E;

	// torque limit range for the immediate stop, in percent
	localparam logic [8:0] TORQUE_LIMIT_MAX = 9'h1F4;
	localparam logic [8:0] TORQUE_LIMIT_RST = 9'h000;

	// number of asynchronous pins passed through the synchroniser
	localparam int PIN_COUNT = 4;
	localparam int PIN_FWD = 0;
	localparam int PIN_REV = 1;
	localparam int PIN_SERVO_ON = 2;
	localparam int PIN_MAINS = 3;

	// sequence states
	typedef enum logic [1:0] {SQ_RUN, SQ_DECEL, SQ_STOP} ssq_state_e;

	// cause of the stop, lowest priority first, except that CS_OT_FWD outranks CS_OT_REV
	typedef enum logic [2:0] {CS_NONE, CS_OT_FWD, CS_OT_REV, CS_SERVO_OFF, CS_MAINS_OFF, CS_ALARM} ssq_cause_e;

	// actions chosen for one stop
	typedef struct packed {
		logic decel_brake; // braking short while slowing
		logic decel_zero_torque; // zero torque in the blocked direction while slowing
		logic decel_immediate; // immediate stop under the torque limit
		logic after_brake; // braking short after the stop
		logic after_zero_torque; // zero torque in the blocked direction after the stop
		logic after_lock; // servo lock with zero position command after the stop
		logic clear_start; // clear deviation when the stop starts
		logic clear_end; // clear deviation when deceleration ends
	} ssq_act_s;

	localparam ssq_act_s ACT_NONE = ssq_act_s'(8'h00);

endpackage

// ---- ssq_props.sv ----
// checker: concurrent properties on the servo stop sequencer ports
`timescale 1ns/1ps
module ssq_props (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// pins and settings
	input wire logic fwd_overtravel_limit,
	input wire logic rev_overtravel_limit,
	input wire logic [15:0] motor_speed,
	input wire logic [1:0] overtravel_input_mode,
	input wire logic [8:0] emergency_torque_limit,
	// outputs watched
	input wire logic braking_short,
	input wire logic immediate_stop,
	input wire logic servo_energised,
	input wire logic torque_limit_en,
	input wire logic [8:0] torque_limit_pct,
	input wire logic deviation_clear,
	input wire logic overtravel_input_alarm,
	input wire logic fwd_drive_blocked,
	input wire logic rev_drive_blocked,
	input wire logic stop_active,
	input wire logic after_stop
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	// clamped torque limit; values above the top are cut back
	logic [8:0] lim_exp;
	assign lim_exp = (emergency_torque_limit > ssq_pkg::TORQUE_LIMIT_MAX) ? ssq_pkg::TORQUE_LIMIT_MAX
		: emergency_torque_limit;
	// forward limit held long enough to cross the two-flop synchroniser
	sequence s_fwd_held;
		(overtravel_input_mode == ssq_pkg::OT_MODE_NORMAL && fwd_overtravel_limit)[*3];
	endsequence
	// either limit held in alarm mode
	sequence s_any_held;
		(overtravel_input_mode == ssq_pkg::OT_MODE_ALARM && (fwd_overtravel_limit || rev_overtravel_limit))[*3];
	endsequence
	// clear drops on the next edge
	sequence s_clear_drop;
		##1 !deviation_clear;
	endsequence
	a_fwd_blocks: assert property (s_fwd_held |=> fwd_drive_blocked)
		else $error("forward limit did not block forward drive");
	a_ignore_flags: assert property (overtravel_input_mode == ssq_pkg::OT_MODE_IGNORE |=>
		!fwd_drive_blocked && !rev_drive_blocked && !overtravel_input_alarm)
		else $error("limit flags raised in ignore mode");
	a_alarm_raise: assert property (s_any_held |=> overtravel_input_alarm)
		else $error("limit in alarm mode gave no alarm");
	a_alarm_mode: assert property (overtravel_input_mode != ssq_pkg::OT_MODE_ALARM |=> !overtravel_input_alarm)
		else $error("overtravel alarm outside alarm mode");
	a_imm_energised: assert property (immediate_stop |-> servo_energised && torque_limit_en)
		else $error("immediate stop without power or torque limit");
	a_limit_value: assert property (!$past(rst) |-> torque_limit_pct == $past(lim_exp))
		else $error("torque limit value wrong");
	a_decel_end: assert property ($rose(after_stop) |-> $past(motor_speed) <= ssq_pkg::STOP_SPEED_RPM)
		else $error("halt entered above stop speed");
	a_after_in_stop: assert property (after_stop |-> stop_active)
		else $error("halt flag outside a stop");
	a_brake_excl: assert property (!(braking_short && immediate_stop))
		else $error("brake and immediate stop together");
	a_clear_single: assert property (deviation_clear |-> s_clear_drop)
		else $error("deviation clear longer than one cycle");
endmodule
bind ssq_servo_stop_sequencer ssq_props u_props (.*);

// ---- ssq_servo_stop_sequencer.sv ----
// module: top of the servo stop sequencer, chooses and runs the stop sequence
//
// Operation
// - mode 0: limits block and stop their direction
// - mode 1: both limit inputs fully ignored
// - mode 2: either limit raises overtravel alarm
// - alarm sequence overrides overtravel stop setting
// - overtravel stop setting used only in mode 0
// - codes 0,1: brake or zero torque, retain
// - code 2: immediate stop, lock, clear twice
// - immediate stop: servo on, torque limited
// - decel ends at 30 r/min, then latched
// - servo off code picks brake, free, clear
// - main power off code 0 to 9 provided
// - main power off: brake after, clear or retain
`timescale 1ns/1ps
module ssq_servo_stop_sequencer (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// limit switch and command pins, asynchronous to mclk
	input wire logic fwd_overtravel_limit,
	input wire logic rev_overtravel_limit,
	input wire logic servo_on_cmd,
	input wire logic main_power_ok,
	// drive state from logic on mclk
	input wire logic drive_error,
	input wire logic error_needs_immediate_stop,
	input wire logic motor_dir_fwd,
	input wire logic [15:0] motor_speed,
	// sequence settings, held steady by the host
	input wire logic [1:0] overtravel_input_mode,
	input wire logic [1:0] overtravel_stop_sequence,
	input wire logic [3:0] servo_off_sequence,
	input wire logic [3:0] main_power_off_sequence,
	input wire logic [2:0] alarm_sequence,
	input wire logic [8:0] emergency_torque_limit,
	// brake and torque command path
	output logic braking_short,
	output logic torque_zero_fwd,
	output logic torque_zero_rev,
	output logic servo_lock_hold,
	output logic immediate_stop,
	output logic servo_energised,
	output logic torque_limit_en,
	output logic [8:0] torque_limit_pct,
	// deviation counter control
	output logic deviation_clear,
	// status
	output logic overtravel_input_alarm,
	output logic fwd_drive_blocked,
	output logic rev_drive_blocked,
	output logic stop_active,
	output logic after_stop
);

	// synchronised pin levels
	logic [ssq_pkg::PIN_COUNT-1:0] pins_raw; // pins gathered for the synchroniser
	logic [ssq_pkg::PIN_COUNT-1:0] pins_s; // pins after two flip-flops
	logic fwd_s; // forward limit, synchronised
	logic rev_s; // reverse limit, synchronised
	logic servo_on_s; // servo on command, synchronised
	logic mains_s; // main power present, synchronised

	// sequence state
	ssq_pkg::ssq_state_e state_r; // current phase of the stop
	ssq_pkg::ssq_state_e state_nxt;
	ssq_pkg::ssq_cause_e cause_r; // cause being served
	ssq_pkg::ssq_cause_e cause_nxt;
	ssq_pkg::ssq_cause_e cause_req; // highest priority cause present now
	ssq_pkg::ssq_act_s act_r; // actions latched when the stop started
	ssq_pkg::ssq_act_s act_nxt;
	logic clear_nxt; // deviation clear pulse for the next cycle

	// request terms
	logic ot_fwd_req; // forward limit hit while moving forward
	logic ot_rev_req; // reverse limit hit while moving in reverse
	logic ot_alarm_nxt; // overtravel alarm condition
	logic error_any; // any error, including the overtravel alarm
	logic slow_enough; // motor at or below the stop speed

	// next output values, all registered together
	logic brake_nxt;
	logic zero_torque_nxt;
	logic lock_nxt;
	logic imm_nxt;
	logic energised_nxt;

	// cause and action channel to the decoder
	ssq_act_if act_if ();

	// pins are asynchronous, so every one passes two flip-flops
	assign pins_raw[ssq_pkg::PIN_FWD] = fwd_overtravel_limit;
	assign pins_raw[ssq_pkg::PIN_REV] = rev_overtravel_limit;
	// servo on and main power idle high but the synchroniser resets to 0;
	// they travel inverted so the first edges after reset read them as
	// present instead of starting a false main power off stop
	assign pins_raw[ssq_pkg::PIN_SERVO_ON] = ~servo_on_cmd;
	assign pins_raw[ssq_pkg::PIN_MAINS] = ~main_power_ok;

	ssq_sync #(
		.W(ssq_pkg::PIN_COUNT)
	) u_sync (
		.mclk(mclk),
		.rst(rst),
		.pin_in(pins_raw),
		.pin_sync(pins_s)
	);

	assign fwd_s = pins_s[ssq_pkg::PIN_FWD];
	assign rev_s = pins_s[ssq_pkg::PIN_REV];
	// undo the inversion taken through the synchroniser
	assign servo_on_s = ~pins_s[ssq_pkg::PIN_SERVO_ON];
	assign mains_s = ~pins_s[ssq_pkg::PIN_MAINS];

	// action table lives in its own module so the sequencer stays readable
	// it is combinational; act_r takes its answer only when a stop starts
	ssq_decode u_decode (
		.overtravel_stop_sequence(overtravel_stop_sequence),
		.servo_off_sequence(servo_off_sequence),
		.main_power_off_sequence(main_power_off_sequence),
		.alarm_sequence(alarm_sequence),
		.error_needs_immediate_stop(error_needs_immediate_stop),
		.act_if(act_if)
	);

	assign act_if.cause = cause_req;

	// limit requests; once served, a limit holds its cause even if the
	// direction flag wobbles while the motor comes to rest
	always_comb begin
		ot_fwd_req = (overtravel_input_mode == ssq_pkg::OT_MODE_NORMAL) && fwd_s
			&& (motor_dir_fwd || (cause_r == ssq_pkg::CS_OT_FWD));
		ot_rev_req = (overtravel_input_mode == ssq_pkg::OT_MODE_NORMAL) && rev_s
			&& (!motor_dir_fwd || (cause_r == ssq_pkg::CS_OT_REV));
		ot_alarm_nxt = (overtravel_input_mode == ssq_pkg::OT_MODE_ALARM) && (fwd_s || rev_s);
		error_any = drive_error || overtravel_input_alarm;
		slow_enough = (motor_speed <= ssq_pkg::STOP_SPEED_RPM);
	end

	// cause priority: alarm, main power off, servo off, forward, reverse;
	// in mode 1 and the unused mode 3 the limits never take part
	// a higher cause arriving mid-stop restarts deceleration with its own actions
	always_comb begin
		if (error_any) begin
			cause_req = ssq_pkg::CS_ALARM;
		end else if (!mains_s) begin
			cause_req = ssq_pkg::CS_MAINS_OFF;
		end else if (!servo_on_s) begin
			cause_req = ssq_pkg::CS_SERVO_OFF;
		end else if (ot_fwd_req) begin
			cause_req = ssq_pkg::CS_OT_FWD;
		end else if (ot_rev_req) begin
			cause_req = ssq_pkg::CS_OT_REV;
		end else begin
			cause_req = ssq_pkg::CS_NONE;
		end
	end

	// sequence transitions and deviation clear points
	always_comb begin
		state_nxt = state_r;
		cause_nxt = cause_r;
		act_nxt = act_r;
		clear_nxt = 1'b0;
		if (cause_req == ssq_pkg::CS_NONE) begin
			// every cause gone: back to normal running
			state_nxt = ssq_pkg::SQ_RUN;
			cause_nxt = ssq_pkg::CS_NONE;
			act_nxt = ssq_pkg::ACT_NONE;
			// deviation kept through an alarm is cleared when it goes
			clear_nxt = (cause_r == ssq_pkg::CS_ALARM);
		end else if (cause_req != cause_r) begin
			// new or higher priority cause restarts the stop
			state_nxt = ssq_pkg::SQ_DECEL;
			cause_nxt = cause_req;
			act_nxt = act_if.act;
			clear_nxt = act_if.act.clear_start || (cause_r == ssq_pkg::CS_ALARM);
		end else if ((state_r == ssq_pkg::SQ_DECEL) && slow_enough && !deviation_clear) begin
			// once slow enough the after-stop action stays, whatever the speed;
			// a stop that starts already slow would put the end clear right
			// after the start clear and merge them, so the halt waits a cycle
			state_nxt = ssq_pkg::SQ_STOP;
			clear_nxt = act_r.clear_end;
		end
	end

	// output values for the next state; the after-stop action in the
	// stop state never looks at speed again
	always_comb begin
		brake_nxt = 1'b0;
		zero_torque_nxt = 1'b0;
		lock_nxt = 1'b0;
		imm_nxt = 1'b0;
		energised_nxt = servo_on_s && mains_s;
		unique case (state_nxt)
			ssq_pkg::SQ_RUN: begin
				energised_nxt = servo_on_s && mains_s;
			end
			ssq_pkg::SQ_DECEL: begin
				brake_nxt = act_nxt.decel_brake;
				zero_torque_nxt = act_nxt.decel_zero_torque;
				imm_nxt = act_nxt.decel_immediate;
				// braking short means the power stage is off
				energised_nxt = act_nxt.decel_immediate || act_nxt.decel_zero_torque;
			end
			ssq_pkg::SQ_STOP: begin
				brake_nxt = act_nxt.after_brake;
				zero_torque_nxt = act_nxt.after_zero_torque;
				lock_nxt = act_nxt.after_lock;
				energised_nxt = act_nxt.after_zero_torque || act_nxt.after_lock;
			end
		endcase
	end

	// sequence state register; act_r freezes the actions chosen at entry,
	// so a setting changed mid-stop only counts from the next stop
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			state_r <= ssq_pkg::SQ_RUN;
			cause_r <= ssq_pkg::CS_NONE;
			act_r <= ssq_pkg::ACT_NONE;
		end else begin
			state_r <= state_nxt;
			cause_r <= cause_nxt;
			act_r <= act_nxt;
		end
	end

	// brake and torque outputs, registered in step with the state
	// one register stage for all keeps brake and torque from disagreeing
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			braking_short <= 1'b0;
			torque_zero_fwd <= 1'b0;
			torque_zero_rev <= 1'b0;
			servo_lock_hold <= 1'b0;
			immediate_stop <= 1'b0;
			servo_energised <= 1'b0;
			torque_limit_en <= 1'b0;
			stop_active <= 1'b0;
			after_stop <= 1'b0;
		end else begin
			braking_short <= brake_nxt;
			torque_zero_fwd <= zero_torque_nxt && (cause_nxt == ssq_pkg::CS_OT_FWD);
			torque_zero_rev <= zero_torque_nxt && (cause_nxt == ssq_pkg::CS_OT_REV);
			servo_lock_hold <= lock_nxt;
			immediate_stop <= imm_nxt;
			servo_energised <= energised_nxt;
			torque_limit_en <= imm_nxt;
			stop_active <= (state_nxt != ssq_pkg::SQ_RUN);
			after_stop <= (state_nxt == ssq_pkg::SQ_STOP);
		end
	end

	// emergency torque limit, clamped to its range; settings above it
	// would let a sudden stop exceed what the stage is rated for
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			torque_limit_pct <= ssq_pkg::TORQUE_LIMIT_RST;
		end else if (emergency_torque_limit > ssq_pkg::TORQUE_LIMIT_MAX) begin
			torque_limit_pct <= ssq_pkg::TORQUE_LIMIT_MAX;
		end else begin
			torque_limit_pct <= emergency_torque_limit;
		end
	end

	// deviation counter clear, one cycle per sequence point
	// the counter itself lives outside; this block only says when
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			deviation_clear <= 1'b0;
		end else begin
			deviation_clear <= clear_nxt;
		end
	end

	// overtravel alarm follows the limit levels in mode 2 only
	// not latched: holding the alarm is the alarm handler's job
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			overtravel_input_alarm <= 1'b0;
		end else begin
			overtravel_input_alarm <= ot_alarm_nxt;
		end
	end

	// drive blocking toward an active limit; the host must also stop
	// commanding that way or the retained deviation keeps growing
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			fwd_drive_blocked <= 1'b0;
			rev_drive_blocked <= 1'b0;
		end else begin
			fwd_drive_blocked <= (overtravel_input_mode == ssq_pkg::OT_MODE_NORMAL) && fwd_s;
			rev_drive_blocked <= (overtravel_input_mode == ssq_pkg::OT_MODE_NORMAL) && rev_s;
		end
	end

endmodule

// ---- ssq_sync.sv ----
// module: two flip-flop synchroniser for a group of asynchronous pins
`timescale 1ns/1ps
module ssq_sync #(
	parameter int W = 1
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// pins in, levels out
	input wire logic [W-1:0] pin_in,
	output logic [W-1:0] pin_sync
);

	logic [W-1:0] meta_r; // first stage, read only by the second stage

	// two stages; the first may go metastable and nothing else looks at it
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			meta_r <= '0;
			pin_sync <= '0;
		end else begin
			meta_r <= pin_in;
			pin_sync <= meta_r;
		end
	end

endmodule

// ---- tb_servo_stop_sequencer.sv ----
// testbench: drives stop causes and checks the chosen stop sequence
`timescale 1ns/1ps
module tb_servo_stop_sequencer;
	// design and model signals, named as their ports
	logic mclk, rst, fwd_overtravel_limit, rev_overtravel_limit, servo_on_cmd, main_power_ok;
	logic drive_error, error_needs_immediate_stop, motor_dir_fwd, slow, kick;
	logic [1:0] overtravel_input_mode, overtravel_stop_sequence;
	logic [3:0] servo_off_sequence, main_power_off_sequence;
	logic [2:0] alarm_sequence;
	logic [8:0] emergency_torque_limit, torque_limit_pct;
	logic [15:0] motor_speed;
	logic braking_short, torque_zero_fwd, torque_zero_rev, servo_lock_hold, immediate_stop, servo_energised;
	logic torque_limit_en, deviation_clear, overtravel_input_alarm, fwd_drive_blocked, rev_drive_blocked;
	logic stop_active, after_stop;
	int errors, checks, clr_cnt, k, c;
	ssq_servo_stop_sequencer dut_u (.*);
	ssq_motor_model motor_u (.*);
	// 50 MHz clock
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	// count clear pulses, one per high cycle
	always @(posedge mclk) begin
		if (deviation_clear === 1'b1) clr_cnt++;
	end
	task automatic complete_run();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
	endtask
	// bounded wait for stop_active (sel 0) or after_stop (sel 1)
	task automatic wait_high(input int sel, input int lim);
		for (int i = 0; i <= lim; i++) begin
			@(posedge mclk);
			#1;
			if ((sel ? after_stop : stop_active) === 1'b1) return;
		end
		errors++;
		complete_run();
	endtask
	// follow one stop: slowing outputs, halt outputs, shaft kick, clear count
	task automatic run_stop(input logic [3:0] e_dec, input logic [2:0] e_aft, input int e_clr);
		#1;
		clr_cnt = 0;
		wait_high(0, 10);
		chk("decel", {immediate_stop, braking_short, torque_zero_fwd, servo_energised}, e_dec);
		wait_high(1, 1100);
		chk("halt", {servo_lock_hold, braking_short, torque_zero_fwd}, e_aft);
		@(posedge mclk);
		kick <= 1'b1;
		@(posedge mclk);
		kick <= 1'b0;
		tick(3);
		#1;
		chk("latched", after_stop, 1'b1);
		chk("clears", clr_cnt, e_clr);
	endtask
	// main sequence
	initial begin
		rst = 1'b1;
		{fwd_overtravel_limit, rev_overtravel_limit, drive_error, error_needs_immediate_stop} = 4'h0;
		{servo_on_cmd, main_power_ok, motor_dir_fwd, slow, kick} = 5'h1C;
		overtravel_input_mode = ssq_pkg::OT_MODE_NORMAL;
		overtravel_stop_sequence = 2'h0;
		servo_off_sequence = 4'h0;
		main_power_off_sequence = 4'h0;
		alarm_sequence = 3'h0;
		emergency_torque_limit = 9'h1F4;
		// deviation excess and travel range limits are the host's, kept generous
		errors = 0;
		checks = 0;
		clr_cnt = 0;
		tick(5);
		rst <= 1'b0;
		tick(4);
		#1;
		chk("idle", stop_active, 1'b0);
		// overtravel codes 0 to 2 while moving forward
		for (k = 0; k < 3; k++) begin
			@(posedge mclk);
			overtravel_stop_sequence <= k[1:0];
			fwd_overtravel_limit <= 1'b1;
			run_stop(k == 0 ? 4'b0100 : k == 1 ? 4'b0011 : 4'b1001, k == 2 ? 3'b100 : 3'b001, k == 2 ? 2 : 0);
			chk("blocked", fwd_drive_blocked, 1'b1);
			chk("torque", torque_limit_pct, 9'h1F4);
			@(posedge mclk);
			fwd_overtravel_limit <= 1'b0;
			tick(6);
		end
		// reverse motion with zero torque code: only the reverse side is held
		@(posedge mclk);
		overtravel_stop_sequence <= ssq_pkg::OT_SEQ_ZERO_TORQUE;
		motor_dir_fwd <= 1'b0;
		rev_overtravel_limit <= 1'b1;
		run_stop(4'b0001, 3'b000, 0);
		chk("rev zero", {torque_zero_rev, rev_drive_blocked}, 2'b11);
		@(posedge mclk);
		rev_overtravel_limit <= 1'b0;
		motor_dir_fwd <= 1'b1;
		tick(6);
		// both limits ignored
		@(posedge mclk);
		overtravel_input_mode <= ssq_pkg::OT_MODE_IGNORE;
		fwd_overtravel_limit <= 1'b1;
		rev_overtravel_limit <= 1'b1;
		tick(6);
		#1;
		chk("ignored", {stop_active, overtravel_input_alarm, fwd_drive_blocked, rev_drive_blocked}, 4'h0);
		// alarm mode: alarm sequence wins over overtravel code 1
		@(posedge mclk);
		overtravel_input_mode <= ssq_pkg::OT_MODE_ALARM;
		fwd_overtravel_limit <= 1'b0;
		run_stop(4'b0100, 3'b010, 0);
		chk("alarm", overtravel_input_alarm, 1'b1);
		@(posedge mclk);
		rev_overtravel_limit <= 1'b0;
		tick(6);
		#1;
		chk("alarm clear", clr_cnt, 1);
		@(posedge mclk);
		overtravel_input_mode <= ssq_pkg::OT_MODE_NORMAL;
		// servo off (c 0) and main power off (c 1), every code
		for (c = 0; c < 2; c++) begin
			for (k = 0; k < 10; k++) begin
				@(posedge mclk);
				servo_off_sequence <= k[3:0];
				main_power_off_sequence <= k[3:0];
				slow <= (k == 0);
				if (c == 0) servo_on_cmd <= 1'b0;
				else main_power_ok <= 1'b0;
				run_stop(k >= 8 ? 4'b1001 : 4'b0100, {1'b0, (c == 1 || k inside {0, 1, 4, 5, 8}), 1'b0},
					k >= 8 ? 2 : (k < 4 ? c + 1 : 0));
				@(posedge mclk);
				servo_on_cmd <= 1'b1;
				main_power_ok <= 1'b1;
				tick(6);
			end
		end
		// drive error with alarm codes 3 and 4
		for (k = 3; k < 5; k++) begin
			@(posedge mclk);
			alarm_sequence <= k[2:0];
			error_needs_immediate_stop <= 1'b1;
			drive_error <= 1'b1;
			run_stop(k == 4 ? 4'b1001 : 4'b0100, 3'b010, 0);
			@(posedge mclk);
			drive_error <= 1'b0;
			tick(4);
		end
		// torque setting above 500 percent is cut back to 500
		@(posedge mclk);
		emergency_torque_limit <= 9'h1FF;
		tick(2);
		#1;
		chk("clamp", torque_limit_pct, 9'h1F4);
		complete_run();
	end
endmodule
